// [hdl/gpt_pkg.sv]
// Constants, field layouts and carrier types for the auxiliary and core-six timer block
package gpt_pkg;

	// ----------------------------------------------------------------
	// Register bus geometry and register indices
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;              // Register index width
	localparam int unsigned DATA_W = 16;             // Register data width
	localparam logic [3:0] ADDR_AUX2_CTRL  = 4'h0;   // Auxiliary timer 2 control
	localparam logic [3:0] ADDR_AUX4_CTRL  = 4'h1;   // Auxiliary timer 4 control
	localparam logic [3:0] ADDR_CORE6_CTRL = 4'h2;   // Core timer 6 control
	localparam logic [3:0] ADDR_AUX2_CNT   = 4'h3;   // Auxiliary timer 2 count
	localparam logic [3:0] ADDR_AUX4_CNT   = 4'h4;   // Auxiliary timer 4 count
	localparam logic [3:0] ADDR_CORE6_CNT  = 4'h5;   // Core timer 6 count

	// ----------------------------------------------------------------
	// Field positions of the core timer 6 control register
	// ----------------------------------------------------------------
	localparam int unsigned C6_IN_LSB  = 0;          // Input select [2:0]
	localparam int unsigned C6_MODE_LSB = 3;         // Mode field [5:3]
	localparam int unsigned C6_RUN     = 6;          // Run bit
	localparam int unsigned C6_DIR     = 7;          // Direction bit
	localparam int unsigned C6_OTL     = 10;         // Output toggle latch
	localparam int unsigned C6_BPS_LSB = 11;         // Block prescaler two [12:11]
	localparam int unsigned C6_CLR     = 14;         // Clear on capture
	localparam int unsigned C6_RELOAD  = 15;         // Reload enable
	localparam logic [15:0] C6_RW_MASK = 16'hDCFF;   // Writable bits of core 6 control
	localparam logic [15:0] AUX_RW_MASK = 16'h13FF;  // Plain writable bits of aux control

	// ----------------------------------------------------------------
	// Reset values, modes and selections
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_RESET  = 16'h0000;  // Control registers after reset
	localparam logic [15:0] CNT_RESET   = 16'h0000;  // Counters after reset
	localparam logic [15:0] CNT_ALL_ONE = 16'hFFFF;  // Up-count wrap point
	localparam logic [2:0]  MODE_TIMER   = 3'h0;     // Timer mode
	localparam logic [2:0]  MODE_COUNTER = 3'h1;     // Counter mode
	localparam logic [2:0]  MODE_GATE_LO = 3'h2;     // Gated, gate active low
	localparam logic [2:0]  MODE_GATE_HI = 3'h3;     // Gated, gate active high
	localparam logic [2:0]  MODE_INC_ROT = 3'h6;     // Incremental, rotation detection
	localparam logic [2:0]  MODE_INC_EDG = 3'h7;     // Incremental, edge detection
	localparam logic [1:0]  EDGE_RISE = 2'h1;        // Low bits: rising edge
	localparam logic [1:0]  EDGE_FALL = 2'h2;        // Low bits: falling edge
	localparam logic [1:0]  EDGE_ANY  = 2'h3;        // Low bits: either edge

	// ----------------------------------------------------------------
	// Prescaler: log2 of the base divisor per block prescaler setting
	// ----------------------------------------------------------------
	localparam int unsigned PRE_W = 12;              // Free-running prescaler width
	localparam logic [3:0] BASE1_LOG [4] = '{4'h3, 4'h2, 4'h5, 4'h4}; // 8,4,32,16
	localparam logic [3:0] BASE2_LOG [4] = '{4'h2, 4'h1, 4'h4, 4'h3}; // 4,2,16,8

	// ----------------------------------------------------------------
	// Auxiliary timer control register layout
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       aux_rotation_dir;     // [15] Current direction, 1 = down
		logic       aux_dir_changed_flag; // [14] Direction change seen
		logic       aux_edge_seen_flag;   // [13] Count edge seen
		logic       aux_irq_disable;      // [12] Incremental interrupt disable
		logic [1:0] spare;                // [11:10] Read as zero
		logic       aux_remote_run_sel;   // [9] Follow core timer 3 run bit
		logic       ext_dir_en;           // [8] Direction from direction pin
		logic       dir_down;             // [7] Software direction
		logic       aux_run_bit;          // [6] Run bit
		logic [2:0] aux_mode_field;       // [5:3] Mode
		logic [2:0] aux_input_select;     // [2:0] Input select
	} gpt_aux_ctrl_t;

endpackage

// [hdl/gpt_aux_core6.sv]
// Auxiliary timers 2 and 4 plus core timer 6, with their control registers
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Remote bit: follow core timer 3 run
// - Interrupt disable blocks incremental flag interrupts
// - Edge flag set per edge, software clears
// - Direction-change flag set, software clears
// - Rotation bit shows direction, one is down
// - Aux prescale: base times two to input
// - Counter mode counts count-pin edges
// - Counter mode counts core 3 latch edges
// - Incremental input selects count/direction pin edges
// - Core 6 counts only while running
// - Core 6 direction bit: up or down
// - Core 6 latch toggles on wrap, writable
// - Block prescaler two base divisor
// - Core 6 input multiplies base divisor
// - Clear on capture zeroes core 6
// - Reload enable loads from capture register
// - Modes 110/111 select incremental operation
// - Without remote, own run bit rules
module gpt_aux_core6
	import gpt_pkg::*;
(
	input  wire logic        clock_i,              // 125 MHz clock
	input  wire logic        rst_i,                // Synchronous reset, high
	input  wire logic [3:0]  reg_addr_i,           // Register index
	input  wire logic [15:0] reg_wdata_i,          // Write data
	input  wire logic        reg_write_i,          // Write strobe
	input  wire logic        reg_read_i,           // Read strobe
	output logic      [15:0] reg_rdata_o,          // Read data, cycle after strobe
	input  wire logic [1:0]  aux_count_pin_i,      // Count pins, [0] timer 2, [1] timer 4
	input  wire logic [1:0]  aux_direction_pin_i,  // Direction pins, same order
	input  wire logic        core3_run_i,          // Core timer 3 run bit
	input  wire logic        core3_toggle_latch_i, // Core timer 3 toggle latch
	input  wire logic [1:0]  block_prescale_one_i, // Block prescaler one setting
	input  wire logic        capture_event_i,      // Capture event pulse
	input  wire logic [15:0] capture_reload_reg_i, // Shared capture/reload value
	output logic      [1:0]  aux_irq_o,            // Aux interrupt requests
	output logic             core6_toggle_latch_o  // Core 6 toggle latch
);

	// ----------------------------------------------------------------
	// Shared prescaler
	// ----------------------------------------------------------------
	logic [PRE_W-1:0] pre_q;                 // Free-running divider
	logic [15:0]      rd_val [6];            // Read values by index
	logic             core3_otl_prev_q;      // Latch value one cycle ago

	// Tick when the low 'sh' bits of the divider are all ones
	function automatic logic pre_hit(input logic [PRE_W-1:0] cnt, input logic [3:0] sh);
		logic [PRE_W:0] m;
		m = ((PRE_W+1)'(1) << sh) - (PRE_W+1)'(1);
		return &(cnt | ~m[PRE_W-1:0]);
	endfunction

	// Divider runs always so that every divisor shares one phase
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	// Core 3 latch is on our clock: one register for its edges
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			core3_otl_prev_q <= 1'b0;
		end else begin
			core3_otl_prev_q <= core3_toggle_latch_i;
		end
	end

	// ----------------------------------------------------------------
	// Auxiliary timers 2 and 4
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_aux
		gpt_aux_ctrl_t ctrl_q;               // Control register
		logic [15:0]   cnt_q;                // Count register
		logic [2:0]    cs_q;                 // Count pin synchroniser
		logic [2:0]    ds_q;                 // Direction pin synchroniser
		logic          clvl_q;               // Accepted count pin level
		logic          dlvl_q;               // Accepted direction pin level
		logic          inc_down_q;           // Direction seen by the decoder
		logic          irq_q;                // Registered request
		logic          cnew, dnew;           // Levels accepted this cycle
		logic          cr, cf, dr, df;       // Pin edges
		logic          lr, lf;               // Core 3 latch edges
		logic          run_eff;              // Effective run
		logic          tick;                 // Prescaled tick
		logic          incr;                 // Incremental mode
		logic          step;                 // Count this cycle
		logic          down_now;             // Direction this cycle
		logic [1:0]    esel;                 // Edge selection
		logic          ctrl_wr, cnt_wr;      // Register writes
		logic          edge_d, chdir_d;      // Flag next values
		gpt_aux_ctrl_t wr_view;              // Write data seen as a control word

		// Three-stage synchronisers; a level counts once stages two and three agree
		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				cs_q   <= '0;
				ds_q   <= '0;
				clvl_q <= 1'b0;
				dlvl_q <= 1'b0;
			end else begin
				cs_q   <= {cs_q[1:0], aux_count_pin_i[i]};
				ds_q   <= {ds_q[1:0], aux_direction_pin_i[i]};
				clvl_q <= cnew;
				dlvl_q <= dnew;
			end
		end

		// Edge detection, mode decode and count qualification
		always_comb begin
			cnew     = (cs_q[1] == cs_q[2]) ? cs_q[2] : clvl_q;
			dnew     = (ds_q[1] == ds_q[2]) ? ds_q[2] : dlvl_q;
			cr       = cnew & ~clvl_q;
			cf       = ~cnew & clvl_q;
			dr       = dnew & ~dlvl_q;
			df       = ~dnew & dlvl_q;
			lr       = core3_toggle_latch_i & ~core3_otl_prev_q;
			lf       = ~core3_toggle_latch_i & core3_otl_prev_q;
			esel     = ctrl_q.aux_input_select[1:0];
			run_eff  = ctrl_q.aux_remote_run_sel ? core3_run_i
			                                     : ctrl_q.aux_run_bit;
			tick     = pre_hit(pre_q, BASE1_LOG[block_prescale_one_i]
			                   + {1'b0, ctrl_q.aux_input_select});
			incr     = (ctrl_q.aux_mode_field == MODE_INC_ROT) ||
			           (ctrl_q.aux_mode_field == MODE_INC_EDG);
			down_now = ctrl_q.ext_dir_en ? dlvl_q : ctrl_q.dir_down;
			step     = 1'b0;
			case (ctrl_q.aux_mode_field)
				MODE_TIMER: begin
					step = run_eff & tick;
				end
				MODE_GATE_LO: begin
					step = run_eff & tick & ~clvl_q;
				end
				MODE_GATE_HI: begin
					step = run_eff & tick & clvl_q;
				end
				MODE_COUNTER: begin
					// Low bits zero select nothing; bit two picks the core 3 latch
					if (ctrl_q.aux_input_select[2]) begin
						step = run_eff & (((esel == EDGE_RISE) & lr) |
						       ((esel == EDGE_FALL) & lf) |
						       ((esel == EDGE_ANY) & (lr | lf)));
					end else begin
						step = run_eff & (((esel == EDGE_RISE) & cr) |
						       ((esel == EDGE_FALL) & cf) |
						       ((esel == EDGE_ANY) & (cr | cf)));
					end
				end
				MODE_INC_ROT, MODE_INC_EDG: begin
					// Reserved upper selections count nothing
					step = run_eff & ~ctrl_q.aux_input_select[2] &
					       ((esel[0] & (cr | cf)) | (esel[1] & (dr | df)));
				end
				default: begin
					step = 1'b0;
				end
			endcase
			// Quadrature decode: direction from the phase of the two pins
			if (incr) begin
				down_now = inc_down_q;
				if (cr | cf) begin
					down_now = (cnew == dnew);
				end else if (dr | df) begin
					down_now = (dnew != cnew);
				end
			end
		end

		assign ctrl_wr = reg_write_i && (reg_addr_i == (i == 0 ? ADDR_AUX2_CTRL : ADDR_AUX4_CTRL));
		assign cnt_wr  = reg_write_i && (reg_addr_i == (i == 0 ? ADDR_AUX2_CNT : ADDR_AUX4_CNT));
		assign wr_view = gpt_aux_ctrl_t'(reg_wdata_i);

		// Flags: a hardware set in the clearing cycle wins over the write
		always_comb begin
			edge_d  = ctrl_wr ? wr_view.aux_edge_seen_flag : ctrl_q.aux_edge_seen_flag;
			chdir_d = ctrl_wr ? wr_view.aux_dir_changed_flag : ctrl_q.aux_dir_changed_flag;
			if (incr & step) begin
				edge_d = 1'b1;
			end
			if (down_now != ctrl_q.aux_rotation_dir) begin
				chdir_d = 1'b1;
			end
		end

		// Control register with hardware-owned status bits
		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				ctrl_q     <= gpt_aux_ctrl_t'(CTRL_RESET);
				inc_down_q <= 1'b0;
			end else begin
				if (ctrl_wr) begin
					ctrl_q <= gpt_aux_ctrl_t'((reg_wdata_i & AUX_RW_MASK) |
					          ({15'h0000, 1'b0} & ~AUX_RW_MASK));
				end
				ctrl_q.aux_edge_seen_flag   <= edge_d;
				ctrl_q.aux_dir_changed_flag <= chdir_d;
				ctrl_q.aux_rotation_dir     <= down_now;
				inc_down_q                  <= down_now;
			end
		end

		// Counter: one step per qualified tick or edge, wrapping both ways
		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				cnt_q <= CNT_RESET;
			end else if (cnt_wr) begin
				cnt_q <= reg_wdata_i;
			end else if (step) begin
				cnt_q <= down_now ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
			end
		end

		// Request stands while an enabled flag is set in incremental mode
		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				irq_q <= 1'b0;
			end else begin
				irq_q <= incr & ~ctrl_q.aux_irq_disable &
				         (ctrl_q.aux_dir_changed_flag |
				          (ctrl_q.aux_edge_seen_flag &
				           (ctrl_q.aux_mode_field == MODE_INC_EDG)));
			end
		end

		assign aux_irq_o[i]  = irq_q;
		assign rd_val[i]     = ctrl_q;
		assign rd_val[i + 3] = cnt_q;
	end

	// ----------------------------------------------------------------
	// Core timer 6
	// ----------------------------------------------------------------
	logic [15:0] c6_ctrl_q;              // Control register
	logic [15:0] c6_cnt_q;               // Count register
	logic        c6_tick;                // Prescaled tick
	logic        c6_step;                // Count this cycle
	logic        c6_down;                // Counting down
	logic        c6_wrap;                // Overflow or underflow
	logic        c6_ctrl_wr, c6_cnt_wr;  // Register writes
	logic        c6_otl_d;               // Toggle latch next value
	logic [1:0]  c6_bps;                 // Block prescaler two
	logic [2:0]  c6_mode;                // Mode field

	assign c6_ctrl_wr = reg_write_i && (reg_addr_i == ADDR_CORE6_CTRL);
	assign c6_cnt_wr  = reg_write_i && (reg_addr_i == ADDR_CORE6_CNT);

	// Tick, step and wrap detection
	always_comb begin
		c6_bps  = c6_ctrl_q[C6_BPS_LSB +: 2];
		c6_mode = c6_ctrl_q[C6_MODE_LSB +: 3];
		c6_tick = pre_hit(pre_q, BASE2_LOG[c6_bps]
		                  + {1'b0, c6_ctrl_q[C6_IN_LSB +: 3]});
		// Reserved modes are not driven by software; they simply never count
		c6_step = (c6_mode == MODE_TIMER) & c6_ctrl_q[C6_RUN] & c6_tick;
		c6_down = c6_ctrl_q[C6_DIR];
		c6_wrap = c6_step & (c6_down ? (c6_cnt_q == CNT_RESET)
		                             : (c6_cnt_q == CNT_ALL_ONE));
		c6_otl_d = (c6_ctrl_wr ? reg_wdata_i[C6_OTL] : c6_ctrl_q[C6_OTL])
		           ^ c6_wrap;
	end

	// Control register; the toggle latch is shared by software and hardware
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			c6_ctrl_q <= CTRL_RESET;
		end else begin
			if (c6_ctrl_wr) begin
				c6_ctrl_q <= reg_wdata_i & C6_RW_MASK;
			end
			c6_ctrl_q[C6_OTL] <= c6_otl_d;
		end
	end

	// Counter: write beats capture clear, which beats counting
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			c6_cnt_q <= CNT_RESET;
		end else if (c6_cnt_wr) begin
			c6_cnt_q <= reg_wdata_i;
		end else if (capture_event_i && c6_ctrl_q[C6_CLR]) begin
			c6_cnt_q <= CNT_RESET;
		end else if (c6_wrap && c6_ctrl_q[C6_RELOAD]) begin
			c6_cnt_q <= capture_reload_reg_i;
		end else if (c6_step) begin
			c6_cnt_q <= c6_down ? c6_cnt_q - 16'h0001
			                    : c6_cnt_q + 16'h0001;
		end
	end

	// Latch output from its own flip-flop
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			core6_toggle_latch_o <= 1'b0;
		end else begin
			core6_toggle_latch_o <= c6_otl_d;
		end
	end

	assign rd_val[2] = c6_ctrl_q;
	assign rd_val[5] = c6_cnt_q;

	// ----------------------------------------------------------------
	// Read port: data valid only in the cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (!reg_read_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_addr_i == ADDR_AUX2_CTRL) begin
			reg_rdata_o <= rd_val[0];
		end else if (reg_addr_i == ADDR_AUX4_CTRL) begin
			reg_rdata_o <= rd_val[1];
		end else if (reg_addr_i == ADDR_CORE6_CTRL) begin
			reg_rdata_o <= rd_val[2];
		end else if (reg_addr_i == ADDR_AUX2_CNT) begin
			reg_rdata_o <= rd_val[3];
		end else if (reg_addr_i == ADDR_AUX4_CNT) begin
			reg_rdata_o <= rd_val[4];
		end else if (reg_addr_i == ADDR_CORE6_CNT) begin
			reg_rdata_o <= rd_val[5];
		end else begin
			reg_rdata_o <= 16'h0000;                // Unmapped reads as zero
		end
	end

endmodule

`default_nettype wire

// [verification/gpt_pins_model.sv]
// Far-side model of the count and direction pins of the auxiliary timers
`timescale 1ns/1ns
`default_nettype none
module gpt_pins_model (
	input  wire logic       clock_i,   // Bench clock
	output logic      [1:0] cnt_pin_o, // Count pins, [0] timer 2
	output logic      [1:0] dir_pin_o  // Direction pins, same order
);
	// ----------------------------------------------------------------
	// Pin driver
	// ----------------------------------------------------------------
	initial begin
		cnt_pin_o = 2'h0;
		dir_pin_o = 2'h0;
	end
	// Toggle one pin n times; each level holds 4 cycles so the 3-stage sync sees it
	task automatic toggle(input bit use_dir, input int idx, input int n);
		repeat (n) begin
			repeat (4) @(posedge clock_i);
			if (use_dir) begin
				dir_pin_o[idx] <= ~dir_pin_o[idx];
			end else begin
				cnt_pin_o[idx] <= ~cnt_pin_o[idx];
			end
		end
		repeat (4) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// [verification/gpt_aux_core6_chk.sv]
// Concurrent checks on the ports of the auxiliary and core-six timer block
`timescale 1ns/1ns
`default_nettype none
module gpt_aux_core6_chk
	import gpt_pkg::*;
(
	input wire logic        clock_i,              // Clock
	input wire logic        rst_i,                // Reset
	input wire logic [3:0]  reg_addr_i,           // Index
	input wire logic [15:0] reg_wdata_i,          // Write data
	input wire logic        reg_write_i,          // Write strobe
	input wire logic        reg_read_i,           // Read strobe
	input wire logic [15:0] reg_rdata_o,          // Read data
	input wire logic [1:0]  aux_irq_o,            // Requests
	input wire logic        core6_toggle_latch_o  // Core 6 latch
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Mirror of the core 6 run bit, so a stopped timer can be recognised
	logic run6_q;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			run6_q <= 1'b0;
		end else if (reg_write_i && reg_addr_i == ADDR_CORE6_CTRL) begin
			run6_q <= reg_wdata_i[C6_RUN];
		end
	end
	sequence wr6_stop;
		reg_write_i && reg_addr_i == ADDR_CORE6_CTRL && !reg_wdata_i[C6_RUN];
	endsequence
	sequence wr2_quiet;
		reg_write_i && reg_addr_i == ADDR_AUX2_CTRL && (reg_wdata_i[12] || reg_wdata_i[5:4] != 2'h3);
	endsequence
	sequence wr2_swdir;
		reg_write_i && reg_addr_i == ADDR_AUX2_CTRL && reg_wdata_i[5:3] == 3'h0 && !reg_wdata_i[8];
	endsequence
	rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
		else $error("read data not zero outside read answer");
	reset_out_a: assert property ($past(rst_i)
		|-> aux_irq_o == 2'h0 && !core6_toggle_latch_o)
		else $error("outputs not cleared by reset");
	unmapped_read_a: assert property (reg_read_i && reg_addr_i > ADDR_CORE6_CNT
		|=> reg_rdata_o == 16'h0000)
		else $error("unmapped index read not zero");
	latch_write_a: assert property (reg_write_i && reg_addr_i == ADDR_CORE6_CTRL
		|=> core6_toggle_latch_o == $past(reg_wdata_i[10]))
		else $error("toggle latch not set by write");
	latch_hold_a: assert property (!run6_q
		&& !(reg_write_i && reg_addr_i == ADDR_CORE6_CTRL) |=> $stable(core6_toggle_latch_o))
		else $error("toggle latch moved while stopped");
	ctrl6_back_a: assert property (wr6_stop ##1 !reg_write_i
		##1 (reg_read_i && reg_addr_i == ADDR_CORE6_CTRL)
		|=> reg_rdata_o == ($past(reg_wdata_i, 3) & C6_RW_MASK))
		else $error("core 6 control read back wrong");
	irq_quiet_a: assert property (wr2_quiet
		##1 !(reg_write_i && reg_addr_i == ADDR_AUX2_CTRL) |=> !aux_irq_o[0])
		else $error("request raised while disabled");
	rot_dir_a: assert property (wr2_swdir ##1 !reg_write_i
		##1 (reg_read_i && reg_addr_i == ADDR_AUX2_CTRL)
		|=> reg_rdata_o[15] == $past(reg_wdata_i[7], 3))
		else $error("rotation bit differs from direction");
endmodule
bind gpt_aux_core6 gpt_aux_core6_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
	.reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .aux_irq_o(aux_irq_o),
	.core6_toggle_latch_o(core6_toggle_latch_o));
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the auxiliary and core-six timer block
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import gpt_pkg::*;
	logic clock_i, rst_i, reg_write_i, reg_read_i, core3_run_i, core3_toggle_latch_i, capture_event_i;
	logic [3:0] reg_addr_i;
	logic [15:0] reg_wdata_i, reg_rdata_o, capture_reload_reg_i;
	logic [1:0] cnt_pin, dir_pin, block_prescale_one_i, aux_irq_o;
	logic core6_toggle_latch_o;
	int mismatches, n_checks;
	gpt_aux_core6 DUT (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .aux_count_pin_i(cnt_pin), .aux_direction_pin_i(dir_pin),
		.core3_run_i(core3_run_i), .core3_toggle_latch_i(core3_toggle_latch_i),
		.block_prescale_one_i(block_prescale_one_i), .capture_event_i(capture_event_i),
		.capture_reload_reg_i(capture_reload_reg_i), .aux_irq_o(aux_irq_o),
		.core6_toggle_latch_o(core6_toggle_latch_o));
	gpt_pins_model pins (.clock_i(clock_i), .cnt_pin_o(cnt_pin), .dir_pin_o(dir_pin));
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	// Bus cycles leave one idle cycle after each strobe, so no strobe is set twice at one edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr_i <= a; reg_wdata_i <= d; reg_write_i <= 1'b1;
		@(posedge clock_i); reg_write_i <= 1'b0; @(posedge clock_i);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		reg_addr_i <= a; reg_read_i <= 1'b1;
		@(posedge clock_i); reg_read_i <= 1'b0;
		#1 v = reg_rdata_o;
		@(posedge clock_i);
	endtask
	// Seen must lie in exp .. exp+tol; an unknown never matches
	task automatic chk(input string nm, input logic [15:0] seen, exp, tol = 16'h0000);
		logic [15:0] df;
		df = seen - exp;
		n_checks++;
		if ((df <= tol) !== 1'b1) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic pulse_cap();
		capture_event_i <= 1'b1; @(posedge clock_i); capture_event_i <= 1'b0; @(posedge clock_i);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic t_regs();
		logic [15:0] v;
		for (int a = 0; a < 7; a++) begin
			rd((a < 6) ? 4'(a) : 4'hF, v); chk("reset value", v, CTRL_RESET);
		end
		wr(4'hF, 16'hFFFF); rd(4'hF, v); chk("unmapped", v, 16'h0000);
		wr(ADDR_CORE6_CTRL, 16'hFF87); rd(ADDR_CORE6_CTRL, v); chk("ctrl6", v, 16'hDC87);
		chk("latch set", 16'(core6_toggle_latch_o), 16'h0001);
		wr(ADDR_CORE6_CTRL, 16'h0000);
		wr(ADDR_AUX2_CTRL, 16'h0080); rd(ADDR_AUX2_CTRL, v); chk("aux dir", v, 16'hC080);
		wr(ADDR_AUX2_CTRL, 16'h0000); rd(ADDR_AUX2_CTRL, v); chk("aux back", v, 16'h4000);
		wr(ADDR_AUX2_CTRL, 16'h0000); rd(ADDR_AUX2_CTRL, v); chk("aux clr", v, 16'h0000);
		$display("test regs done");
	endtask
	task automatic t_core6();
		logic [15:0] v, w;
		wr(ADDR_CORE6_CNT, 16'hFFF8); wr(ADDR_CORE6_CTRL, 16'h0840); repeat (41) @(posedge clock_i);
		chk("latch wrap", 16'(core6_toggle_latch_o), 16'h0001);
		wr(ADDR_CORE6_CTRL, 16'h0C00); rd(ADDR_CORE6_CNT, v); chk("up", v, 16'h000B, 16'h0003);
		repeat (30) @(posedge clock_i);
		rd(ADDR_CORE6_CNT, w); chk("stopped", w, v);
		wr(ADDR_CORE6_CNT, 16'h0008); wr(ADDR_CORE6_CTRL, 16'h0CC0); repeat (41) @(posedge clock_i);
		chk("latch under", 16'(core6_toggle_latch_o), 16'h0000);
		wr(ADDR_CORE6_CTRL, 16'h0800); rd(ADDR_CORE6_CNT, v); chk("down", v, 16'hFFF2, 16'h0003);
		capture_reload_reg_i <= 16'h1230;
		wr(ADDR_CORE6_CNT, 16'hFFFC); wr(ADDR_CORE6_CTRL, 16'h8840); repeat (41) @(posedge clock_i);
		wr(ADDR_CORE6_CTRL, 16'h0000); rd(ADDR_CORE6_CNT, v); chk("reload", v, 16'h123F, 16'h0003);
		wr(ADDR_CORE6_CNT, 16'h0100); wr(ADDR_CORE6_CTRL, 16'h4000); pulse_cap();
		rd(ADDR_CORE6_CNT, v); chk("clear", v, 16'h0000);
		wr(ADDR_CORE6_CTRL, 16'h0000); wr(ADDR_CORE6_CNT, 16'h0100); pulse_cap();
		rd(ADDR_CORE6_CNT, v); chk("no clear", v, 16'h0100);
		$display("test core6 done");
	endtask
	task automatic t_pre();
		logic [15:0] v;
		int lg [4] = '{2, 1, 4, 3};
		for (int b = 0; b < 4; b++) begin
			block_prescale_one_i <= 2'(b);
			wr(ADDR_AUX2_CNT, 16'h0000); wr(ADDR_AUX2_CTRL, 16'h0040); repeat (254) @(posedge clock_i);
			wr(ADDR_AUX2_CTRL, 16'h0000); rd(ADDR_AUX2_CNT, v);
			chk("aux pre", v, 16'((256 >> (lg[b] + 1)) - 1), 16'h0002);
			wr(ADDR_CORE6_CNT, 16'h0000); wr(ADDR_CORE6_CTRL, 16'h0041 | 16'(b << 11));
			repeat (254) @(posedge clock_i);
			wr(ADDR_CORE6_CTRL, 16'h0000); rd(ADDR_CORE6_CNT, v);
			chk("core6 pre", v, 16'((256 >> (lg[b] + 1)) - 1), 16'h0002);
		end
		$display("test prescale done");
	endtask
	task automatic t_count();
		logic [15:0] v;
		logic [15:0] ctl [5] = '{16'h0049, 16'h004A, 16'h020B, 16'h0048, 16'h0249};
		logic [15:0] ex [5] = '{16'h0004, 16'h0004, 16'h0008, 16'h0000, 16'h0000};
		for (int i = 0; i < 5; i++) begin
			core3_run_i <= (i == 2);
			wr(ADDR_AUX2_CNT, 16'h0000); wr(ADDR_AUX2_CTRL, ctl[i]); pins.toggle(0, 0, 8);
			wr(ADDR_AUX2_CTRL, 16'h0000); rd(ADDR_AUX2_CNT, v);
			chk("pin edges", v, ex[i]);
			if (i > 3) continue;
			wr(ADDR_AUX4_CNT, 16'h0000); wr(ADDR_AUX4_CTRL, 16'h004C | 16'((i + 1) % 4));
			repeat (8) begin
				repeat (4) @(posedge clock_i);
				core3_toggle_latch_i <= ~core3_toggle_latch_i;
			end
			repeat (4) @(posedge clock_i);
			wr(ADDR_AUX4_CTRL, 16'h0000); rd(ADDR_AUX4_CNT, v);
			chk("latch edges", v, ex[i]);
		end
		// Gated modes with the count pin low: only the active-low gate lets ticks through
		block_prescale_one_i <= 2'h3;
		wr(ADDR_AUX2_CNT, 16'h0000); wr(ADDR_AUX2_CTRL, 16'h0058); repeat (62) @(posedge clock_i);
		wr(ADDR_AUX2_CTRL, 16'h0050); repeat (30) @(posedge clock_i);
		wr(ADDR_AUX2_CTRL, 16'h0000); rd(ADDR_AUX2_CNT, v);
		chk("gated", v, 16'h0002);
		$display("test count done");
	endtask
	task automatic t_inc();
		logic [15:0] v;
		wr(ADDR_AUX2_CNT, 16'h0000); wr(ADDR_AUX2_CTRL, 16'h007B);
		repeat (2) begin pins.toggle(0, 0, 1); pins.toggle(1, 0, 1); end
		rd(ADDR_AUX2_CTRL, v); chk("flags up", v & 16'hE000, 16'h2000);
		chk("irq", 16'(aux_irq_o[0]), 16'h0001);
		rd(ADDR_AUX2_CNT, v); chk("inc up", v, 16'h0004);
		repeat (2) begin pins.toggle(1, 0, 1); pins.toggle(0, 0, 1); end
		rd(ADDR_AUX2_CTRL, v); chk("flags dn", v & 16'hE000, 16'hE000);
		rd(ADDR_AUX2_CNT, v); chk("inc dn", v, 16'h0000);
		// Flags kept set while the disable bit alone must silence the request
		wr(ADDR_AUX2_CTRL, 16'h707B); rd(ADDR_AUX2_CTRL, v);
		chk("kept", v & 16'hE000, 16'hE000);
		chk("irq off", 16'(aux_irq_o[0]), 16'h0000);
		wr(ADDR_AUX2_CTRL, 16'h107B); rd(ADDR_AUX2_CTRL, v);
		chk("cleared", v & 16'hE000, 16'h8000);
		wr(ADDR_AUX2_CTRL, 16'h1078); pins.toggle(0, 0, 2);
		rd(ADDR_AUX2_CNT, v); chk("sel stop", v, 16'h0000);
		wr(ADDR_AUX4_CTRL, 16'h0079); pins.toggle(0, 1, 1); rd(ADDR_AUX4_CTRL, v);
		chk("edge4", v & 16'hE000, 16'h2000);
		chk("irq4", 16'(aux_irq_o[1]), 16'h0001);
		$display("test incremental done");
	endtask
	initial begin
		repeat (30000) @(posedge clock_i);
		mismatches++;
		close_out();
	end
	initial begin
		rst_i = 1'b1; reg_addr_i = 4'h0; reg_wdata_i = 16'h0000; reg_write_i = 1'b0;
		reg_read_i = 1'b0; core3_run_i = 1'b0; core3_toggle_latch_i = 1'b0;
		block_prescale_one_i = 2'h0; capture_event_i = 1'b0; capture_reload_reg_i = 16'h0000;
		mismatches = 0; n_checks = 0;
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		t_regs(); t_core6(); t_pre(); t_count(); t_inc();
		close_out();
	end
endmodule
`default_nettype wire
